// ==== aclm_rule_match.sv ====
// Rule match-field byte, range upper byte, compare logic and L2 timer/counter
module aclm_rule_match #(
    parameter logic [3:0] PORT_NUM = 4'h1,
    parameter int         CNT_W    = aclm_pkg::ACLM_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    input  wire logic [CNT_W-1:0] action_count,
    input  wire logic [7:0]       forward_field,
    input  wire logic [47:0]      rule_mac,
    input  wire logic [15:0]      rule_ethertype,
    input  wire logic [31:0]      rule_ip,
    input  wire logic [31:0]      rule_ip_mask,
    input  wire logic [7:0]       rule_protocol,
    input  wire logic [7:0]       rule_range_max_low,
    input  wire logic [15:0]      rule_range_min,
    input  wire logic             pkt_valid,
    input  wire logic [47:0]      pkt_mac_da,
    input  wire logic [47:0]      pkt_mac_sa,
    input  wire logic [15:0]      pkt_ethertype,
    input  wire logic [31:0]      pkt_ip_da,
    input  wire logic [31:0]      pkt_ip_sa,
    input  wire logic [7:0]       pkt_protocol,
    input  wire logic [15:0]      pkt_port_da,
    input  wire logic [15:0]      pkt_port_sa,
    input  wire logic [31:0]      pkt_tcp_seq,
    output logic                  match_valid,
    output logic                  match_hit,
    output logic                  timer_irq,
    output logic                  timer_flag
);
    import aclm_pkg::*;

    // Widths of the control-byte fields and of the tested sequence slice
    localparam int TSEL_W = 3;
    localparam int PORT_W = 4;
    localparam int SEQ_W  = 16;

    // ************************************************************
    // Indirect access registers
    // ************************************************************
    logic [7:0] ind_ctrl;
    logic [7:0] ind_ofs;
    logic [7:0] rule_match_control;
    logic [7:0] rule_range_max_high;

    wire [TSEL_W-1:0] ind_table = ind_ctrl[ACLM_TSEL_LSB +: TSEL_W];
    wire [PORT_W-1:0] ind_port  = ind_ctrl[PORT_W-1:0];
    // Data window accesses aimed at another table or port are dropped silently
    wire       ind_hit   = (ind_table == ACLM_TABLE_RULE) && (ind_port == PORT_NUM);
    wire       data_sel  = (reg_addr == ACLM_ADDR_IND_DATA) && ind_hit;
    wire       wr_ctrl   = reg_wr && (reg_addr == ACLM_ADDR_IND_CTRL);
    wire       wr_ofs    = reg_wr && (reg_addr == ACLM_ADDR_IND_OFS);
    wire       wr_match  = reg_wr && data_sel && (ind_ofs == ACLM_OFS_MATCH);
    wire       wr_range  = reg_wr && data_sel && (ind_ofs == ACLM_OFS_RANGE_HI);
    wire       wr_status = reg_wr && (reg_addr == ACLM_ADDR_STATUS);

    wire [1:0] rule_mode     = rule_match_control[ACLM_MODE_LSB +: 2];
    wire [1:0] match_submode = rule_match_control[ACLM_SUB_LSB +: 2];
    wire       src_dst_sel   = rule_match_control[ACLM_SD_BIT];
    wire       compare_equal = rule_match_control[ACLM_EQ_BIT];

    // Reserved top bits of the match byte stay zero
    always_ff @(posedge clk) begin
        if (srst) begin
            ind_ctrl            <= ACLM_RST_BYTE;
            ind_ofs             <= ACLM_RST_BYTE;
            rule_match_control  <= ACLM_RST_BYTE;
            rule_range_max_high <= ACLM_RST_BYTE;
        end else begin
            if (wr_ctrl) begin
                ind_ctrl <= reg_wdata;
            end
            if (wr_ofs) begin
                ind_ofs <= reg_wdata;
            end
            if (wr_match) begin
                rule_match_control <= {2'b00, reg_wdata[5:0] & ACLM_MATCH_WMASK};
            end
            if (wr_range) begin
                rule_range_max_high <= reg_wdata;
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = ACLM_RST_BYTE;
        case (reg_addr)
            ACLM_ADDR_IND_CTRL: rd_mux = ind_ctrl;
            ACLM_ADDR_IND_OFS:  rd_mux = ind_ofs;
            ACLM_ADDR_STATUS:   rd_mux = {7'h00, timer_flag};
            ACLM_ADDR_IND_DATA: begin
                if (ind_hit && ind_ofs == ACLM_OFS_MATCH) begin
                    rd_mux = rule_match_control;
                end else if (ind_hit && ind_ofs == ACLM_OFS_RANGE_HI) begin
                    rd_mux = rule_range_max_high;
                end
            end
            default: rd_mux = ACLM_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= ACLM_RST_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // ************************************************************
    // Field compare
    // ************************************************************
    wire [47:0] sel_mac  = src_dst_sel ? pkt_mac_sa : pkt_mac_da;
    wire [31:0] sel_ip   = src_dst_sel ? pkt_ip_sa : pkt_ip_da;
    wire [15:0] sel_port = src_dst_sel ? pkt_port_sa : pkt_port_da;
    wire [15:0] range_max = {rule_range_max_high, rule_range_max_low};

    wire eq_mac   = (sel_mac == rule_mac);
    wire eq_type  = (pkt_ethertype == rule_ethertype);
    wire eq_ip    = ((sel_ip & rule_ip_mask) == (rule_ip & rule_ip_mask));
    wire eq_sa_da = (pkt_ip_sa == pkt_ip_da);
    wire eq_proto = (pkt_protocol == rule_protocol);
    // Inclusive bounds, so a value equal to either limit hits
    wire in_port  = (sel_port >= rule_range_min) && (sel_port <= range_max);
    // Sequence range is only 16 bits wide, so the low half of the number is tested
    wire in_seq   = (pkt_tcp_seq[SEQ_W-1:0] >= rule_range_min) &&
                    (pkt_tcp_seq[SEQ_W-1:0] <= range_max);

    // Compare result before polarity, and whether the sub-mode is usable
    logic cmp_equal;
    logic cmp_ok;
    always_comb begin
        cmp_equal = 1'b0;
        cmp_ok    = 1'b0;
        case (rule_mode)
            ACLM_MD_L2: begin
                cmp_ok = 1'b1;
                case (match_submode)
                    ACLM_SUB_1: cmp_equal = eq_type;
                    ACLM_SUB_2: cmp_equal = eq_mac;
                    default:    cmp_equal = eq_mac && eq_type;
                endcase
            end
            ACLM_MD_L3: begin
                case (match_submode)
                    ACLM_SUB_1: begin
                        cmp_ok    = 1'b1;
                        cmp_equal = eq_ip;
                    end
                    ACLM_SUB_2: begin
                        cmp_ok    = 1'b1;
                        cmp_equal = eq_sa_da;
                    end
                    default: cmp_ok = 1'b0;
                endcase
            end
            ACLM_MD_L4: begin
                cmp_ok = 1'b1;
                case (match_submode)
                    ACLM_SUB_0: cmp_equal = eq_proto;
                    ACLM_SUB_3: cmp_equal = in_seq;
                    default:    cmp_equal = in_port;
                endcase
            end
            default: cmp_ok = 1'b0;
        endcase
    end

    // ************************************************************
    // Match result
    // ************************************************************
    wire next_hit  = cmp_ok && (compare_equal ? cmp_equal : !cmp_equal);
    wire cnt_mode  = (rule_mode == ACLM_MD_L2) && (match_submode == ACLM_SUB_0);
    // Count mode qualifies on a plain MAC and type equality
    wire qual_pkt  = pkt_valid && cnt_mode && eq_mac && eq_type;

    // Hit rises only with valid, so a stale compare never leaks out
    always_ff @(posedge clk) begin
        if (srst) begin
            match_valid <= 1'b0;
            match_hit   <= 1'b0;
        end else begin
            match_valid <= pkt_valid;
            match_hit   <= pkt_valid && next_hit;
        end
    end

    // ************************************************************
    // Unit tick
    // ************************************************************
    // Free-running divider: the first unit after a load can be up to one unit short
    logic tick_us;
    logic tick_ms;

    aclm_tick #(
        .CYC_PER_US (ACLM_CYC_PER_US),
        .US_PER_MS  (ACLM_US_PER_MS)
    ) u_tick (
        .clk     (clk),
        .srst    (srst),
        .tick_us (tick_us),
        .tick_ms (tick_ms)
    );

    wire unit_tick = forward_field[ACLM_FWD_MS] ? tick_ms : tick_us;
    wire count_up  = forward_field[ACLM_FWD_UP];

    // ************************************************************
    // Timer state machine
    // ************************************************************
    aclm_tmr_e        tmr_state;
    aclm_tmr_e        next_tmr_state;
    logic [CNT_W-1:0] tmr_cnt;
    logic [CNT_W-1:0] next_tmr_cnt;
    logic             next_irq;

    always_comb begin
        next_tmr_state = tmr_state;
        next_tmr_cnt   = tmr_cnt;
        next_irq       = 1'b0;
        case (tmr_state)
            ACLM_TMR_IDLE: begin
                next_tmr_cnt = '0;
                if (cnt_mode) begin
                    next_tmr_state = count_up ? ACLM_TMR_UP : ACLM_TMR_DOWN;
                end
            end
            ACLM_TMR_DOWN: begin
                if (!cnt_mode || count_up) begin
                    next_tmr_state = ACLM_TMR_IDLE;
                end else if (qual_pkt) begin
                    // Each qualified packet restarts the measured gap
                    next_tmr_cnt = action_count;
                end else if (unit_tick && tmr_cnt != '0) begin
                    next_tmr_cnt = tmr_cnt - CNT_W'(1);
                    next_irq     = (tmr_cnt == CNT_W'(1));
                end
            end
            ACLM_TMR_UP: begin
                if (!cnt_mode || !count_up) begin
                    next_tmr_state = ACLM_TMR_IDLE;
                end else if (qual_pkt) begin
                    // Testing count+1 lets an action count of 0 or 1 fire every packet
                    if (tmr_cnt + CNT_W'(1) >= action_count) begin
                        next_tmr_cnt = '0;
                        next_irq     = 1'b1;
                    end else begin
                        next_tmr_cnt = tmr_cnt + CNT_W'(1);
                    end
                end
            end
            default: next_tmr_state = ACLM_TMR_IDLE;
        endcase
    end

    // ************************************************************
    // Status flag
    // ************************************************************
    // Set beats a same-cycle software clear so no expiry is lost
    wire flag_clr = wr_status && reg_wdata[ACLM_STAT_FLAG];

    always_ff @(posedge clk) begin
        if (srst) begin
            tmr_state  <= ACLM_TMR_IDLE;
            tmr_cnt    <= '0;
            timer_irq  <= 1'b0;
            timer_flag <= 1'b0;
        end else begin
            tmr_state  <= next_tmr_state;
            tmr_cnt    <= next_tmr_cnt;
            timer_irq  <= next_irq;
            timer_flag <= next_irq || (timer_flag && !flag_clr);
        end
    end
endmodule // aclm_rule_match

// ==== aclm_pkg.sv ====
// Package of constants for the access-control rule match-field block
package aclm_pkg;

    // ************************************************************
    // Indirect register map
    // ************************************************************
    localparam logic [7:0] ACLM_ADDR_IND_CTRL = 8'h6E;
    localparam logic [7:0] ACLM_ADDR_IND_OFS  = 8'h6F;
    localparam logic [7:0] ACLM_ADDR_IND_DATA = 8'hA0;
    localparam logic [7:0] ACLM_ADDR_STATUS   = 8'hB0;
    localparam logic [2:0] ACLM_TABLE_RULE    = 3'h2;
    localparam logic [7:0] ACLM_OFS_MATCH     = 8'h01;
    localparam logic [7:0] ACLM_OFS_RANGE_HI  = 8'h02;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int ACLM_TSEL_LSB  = 5;
    localparam int ACLM_MODE_LSB  = 4;
    localparam int ACLM_SUB_LSB   = 2;
    localparam int ACLM_SD_BIT    = 1;
    localparam int ACLM_EQ_BIT    = 0;
    localparam int ACLM_FWD_MS    = 4;
    localparam int ACLM_FWD_UP    = 3;
    localparam int ACLM_STAT_FLAG = 0;
    localparam logic [7:0] ACLM_RST_BYTE = 8'h00;
    localparam logic [5:0] ACLM_MATCH_WMASK = 6'h3F;

    // ************************************************************
    // Mode and sub-mode codes
    // ************************************************************
    localparam logic [1:0] ACLM_MD_OFF = 2'h0;
    localparam logic [1:0] ACLM_MD_L2  = 2'h1;
    localparam logic [1:0] ACLM_MD_L3  = 2'h2;
    localparam logic [1:0] ACLM_MD_L4  = 2'h3;
    localparam logic [1:0] ACLM_SUB_0  = 2'h0;
    localparam logic [1:0] ACLM_SUB_1  = 2'h1;
    localparam logic [1:0] ACLM_SUB_2  = 2'h2;
    localparam logic [1:0] ACLM_SUB_3  = 2'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int ACLM_CLK_PS    = 5000;
    localparam int ACLM_US_PS     = 1000000;
    localparam int ACLM_CYC_PER_US = ACLM_US_PS / ACLM_CLK_PS;
    localparam int ACLM_US_PER_MS = 1000;
    localparam int ACLM_CNT_W     = 11;

    typedef enum logic [1:0] {
        ACLM_TMR_IDLE = 2'b00,
        ACLM_TMR_DOWN = 2'b01,
        ACLM_TMR_UP   = 2'b10
    } aclm_tmr_e;

endpackage

// ==== aclm_tick.sv ====
// Microsecond and millisecond enable pulse divider
module aclm_tick #(
    parameter int CYC_PER_US = 200,
    parameter int US_PER_MS  = 1000
) (
    input  wire logic clk,
    input  wire logic srst,
    output logic      tick_us,
    output logic      tick_ms
);
    localparam int UW = $clog2(CYC_PER_US + 1);
    localparam int MW = $clog2(US_PER_MS + 1);
    localparam logic [UW-1:0] U_LAST = UW'(CYC_PER_US - 1);
    localparam logic [MW-1:0] M_LAST = MW'(US_PER_MS - 1);

    logic [UW-1:0] cnt_us;
    logic [MW-1:0] cnt_ms;
    wire           us_wrap = (cnt_us == U_LAST);
    wire           ms_wrap = us_wrap && (cnt_ms == M_LAST);

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_us  <= '0;
            cnt_ms  <= '0;
            tick_us <= 1'b0;
            tick_ms <= 1'b0;
        end else begin
            cnt_us  <= us_wrap ? '0 : cnt_us + UW'(1);
            if (us_wrap) begin
                cnt_ms <= (cnt_ms == M_LAST) ? '0 : cnt_ms + MW'(1);
            end
            tick_us <= us_wrap;
            tick_ms <= ms_wrap;
        end
    end
endmodule // aclm_tick

// ==== aclm_rule_match_sva.sv ====
// Port checker for the rule match-field block
module aclm_rule_match_chk
    import aclm_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       pkt_valid,
    input wire logic       match_valid,
    input wire logic       match_hit,
    input wire logic       timer_irq,
    input wire logic       timer_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    wire clr_req = reg_wr && reg_addr == ACLM_ADDR_STATUS && reg_wdata[ACLM_STAT_FLAG];
    wire unmapped = !(reg_addr inside {ACLM_ADDR_IND_CTRL, ACLM_ADDR_IND_OFS,
                                        ACLM_ADDR_IND_DATA, ACLM_ADDR_STATUS});

    // ************************************************************
    // Sequences and properties
    // ************************************************************
    sequence s_clear;
        timer_flag && clr_req;
    endsequence

    a_valid_follows: assert property (pkt_valid |=> match_valid)
        else $error("no result after packet");
    a_valid_quiet: assert property (!pkt_valid |=> !match_valid)
        else $error("result without packet");
    a_hit_gated: assert property (!match_valid |-> !match_hit)
        else $error("hit outside result cycle");
    a_irq_pulse: assert property (timer_irq && !pkt_valid |=> !timer_irq)
        else $error("interrupt longer than one cycle");
    a_irq_flag: assert property (timer_irq |-> timer_flag)
        else $error("interrupt without flag");
    a_flag_sticky: assert property (timer_flag && !clr_req |=> timer_flag)
        else $error("flag dropped by itself");
    a_flag_clear: assert property (s_clear |=> !timer_flag || timer_irq)
        else $error("flag not cleared");
    a_rd_unmapped: assert property (reg_rd && unmapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_status_read: assert property (reg_rd && reg_addr == ACLM_ADDR_STATUS
        |=> reg_rdata[0] == $past(timer_flag))
        else $error("status read wrong");
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> !match_valid && !timer_irq
        && !timer_flag && reg_rdata == 8'h00)
        else $error("outputs not cleared by reset");
endmodule // aclm_rule_match_chk

bind aclm_rule_match aclm_rule_match_chk aclm_rule_match_chk_i (
    .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
    .match_valid(match_valid), .match_hit(match_hit), .timer_irq(timer_irq),
    .timer_flag(timer_flag));

// ==== aclm_rule_match_test.sv ====
// Self-checking bench for the rule match-field block
module aclm_rule_match_test;
    timeunit 1ns;
    timeprecision 100ps;
    import aclm_pkg::*;
    localparam logic [47:0] R_MAC = 48'h0200_0000_0A01;
    localparam logic [15:0] R_TYPE = 16'h88B5;
    localparam logic [31:0] R_IP = 32'hC0A8_0A01;
    logic        clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, pkt_valid = 0;
    logic [7:0]  reg_addr = 0, reg_wdata = 0, fwd = 0, p_pro = 8'h06, r_pro = 8'h06;
    logic [10:0] act_cnt = 0;
    logic [15:0] p_type = R_TYPE, p_pda = 16'h0150, p_seq = 16'h0150;
    logic [31:0] p_ipd = R_IP, p_ips = R_IP, r_msk = 32'hFFFF_FF00;
    logic [15:0] r_min = 16'h0100;
    logic [7:0]  rdata;
    logic        mv, mh, irq, flag;
    int          n_fail = 0, total_checks = 0, n;
    // Ctrl byte, field to disturb, expected hit
    logic [15:0] rows[24] = '{16'hC100, 16'h1501, 16'h1510, 16'h1411, 16'h1901, 16'h1B00,
        16'h1A01, 16'h1D01, 16'h1D10, 16'h2501, 16'h2561, 16'h2700, 16'h2900, 16'h2921,
        16'h2801, 16'h2100, 16'h2C00, 16'h3101, 16'h3130, 16'h3541, 16'h3700, 16'h3901,
        16'h3D01, 16'h3D50};

    aclm_rule_match aclm_rule_match_i (.clk(clk), .srst(srst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
        .action_count(act_cnt), .forward_field(fwd), .rule_mac(R_MAC),
        .rule_ethertype(R_TYPE), .rule_ip(R_IP), .rule_ip_mask(r_msk),
        .rule_protocol(r_pro), .rule_range_max_low(8'h00), .rule_range_min(r_min),
        .pkt_valid(pkt_valid), .pkt_mac_da(R_MAC), .pkt_mac_sa(R_MAC ^ 48'h1),
        .pkt_ethertype(p_type), .pkt_ip_da(p_ipd), .pkt_ip_sa(p_ips), .pkt_protocol(p_pro),
        .pkt_port_da(p_pda), .pkt_port_sa(16'h0300), .pkt_tcp_seq({16'h0000, p_seq}),
        .match_valid(mv), .match_hit(mh), .timer_irq(irq), .timer_flag(flag));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s: %h not %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 0;
    endtask

    task automatic rdck(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge clk);
        #1;
        reg_rd = 1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 0;
        check(rdata, e, what);
    endtask

    task automatic pkt();
        @(posedge clk);
        #1;
        pkt_valid = 1;
        @(posedge clk);
        #1;
        pkt_valid = 0;
    endtask

    // Bounded wait; running out ends the run
    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 2000) begin
            @(posedge clk);
            #1;
            c++;
        end
        if (c == 2000) begin
            n_fail++;
            final_report();
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge clk);
        #1;
        srst = 0;
        wr(ACLM_ADDR_IND_CTRL, 8'h41);
        wr(ACLM_ADDR_IND_OFS, ACLM_OFS_RANGE_HI);
        rdck(ACLM_ADDR_IND_DATA, 8'h00, "range reset");
        wr(ACLM_ADDR_IND_DATA, 8'h02);
        rdck(ACLM_ADDR_IND_DATA, 8'h02, "range rw");
        wr(ACLM_ADDR_IND_CTRL, 8'h42);
        rdck(ACLM_ADDR_IND_DATA, 8'h00, "other port");
        wr(ACLM_ADDR_IND_CTRL, 8'h21);
        rdck(ACLM_ADDR_IND_DATA, 8'h00, "other table");
        rdck(8'h55, 8'h00, "unmapped");
        wr(ACLM_ADDR_IND_CTRL, 8'h41);
        wr(ACLM_ADDR_IND_OFS, ACLM_OFS_MATCH);
        rdck(ACLM_ADDR_IND_DATA, 8'h00, "match reset");
        $display("registers done");
        foreach (rows[i]) begin
            p_type = R_TYPE;
            p_ips = R_IP ^ 32'h100;
            p_ipd = R_IP;
            p_pro = 8'h06;
            p_pda = 16'h0150;
            p_seq = 16'h0150;
            case (rows[i][7:4])
                4'h1: p_type = 16'h0800;
                4'h2: p_ips = R_IP;
                4'h3: p_pro = 8'h11;
                4'h4: p_pda = 16'h0200;
                4'h5: p_seq = 16'h0201;
                4'h6: p_ipd = R_IP ^ 32'hFF;
                default: ;
            endcase
            wr(ACLM_ADDR_IND_DATA, rows[i][15:8]);
            rdck(ACLM_ADDR_IND_DATA, rows[i][15:8] & 8'h3F, "match byte");
            pkt();
            check({6'h00, mv, mh}, {7'h01, rows[i][0]}, "hit");
        end
        $display("match table done");
        act_cnt = 11'h002;
        wr(ACLM_ADDR_IND_DATA, 8'h10);
        pkt();
        repeat (150) @(posedge clk);
        check({7'h00, flag}, 8'h00, "early expiry");
        pkt();
        wait_irq(n);
        check({7'h00, n >= 195}, 8'h01, "reload");
        check({7'h00, n <= 400}, 8'h01, "expiry late");
        rdck(ACLM_ADDR_STATUS, 8'h01, "status set");
        wr(ACLM_ADDR_STATUS, 8'h01);
        rdck(ACLM_ADDR_STATUS, 8'h00, "status clear");
        fwd = 8'h08;
        act_cnt = 11'h003;
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < 7; i++) begin
            p_type = (i == 1) ? 16'h0800 : R_TYPE;
            pkt();
            check({7'h00, irq}, {7'h00, (i == 3 || i == 6)}, "count up");
        end
        wr(ACLM_ADDR_STATUS, 8'h01);
        fwd = 8'h10;
        act_cnt = 11'h001;
        repeat (2) @(posedge clk);
        pkt();
        repeat (1000) @(posedge clk);
        check({7'h00, flag}, 8'h00, "ms unit");
        $display("timer done");
        @(posedge clk);
        #1;
        srst = 1;
        repeat (2) @(posedge clk);
        #1;
        srst = 0;
        check({4'h0, mv, mh, irq, flag}, 8'h00, "outputs after reset");
        wr(ACLM_ADDR_IND_CTRL, 8'h41);
        wr(ACLM_ADDR_IND_OFS, ACLM_OFS_RANGE_HI);
        rdck(ACLM_ADDR_IND_DATA, 8'h00, "range after reset");
        $display("reset done");
        final_report();
    end
endmodule // aclm_rule_match_test
